// ===== core/timer16_pwm_pkg.sv
// Shared constants and types for the 16-bit timer waveform generator.
package timer16_pwm_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // ------------------------------------------------------------------
    // Register offsets (word addresses on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_COUNTER = 4'h1;
    localparam logic [3:0] ADDR_CMP_A = 4'h2;
    localparam logic [3:0] ADDR_CMP_B = 4'h3;
    localparam logic [3:0] ADDR_CAPTURE = 4'h4;
    localparam logic [3:0] ADDR_FLAGS = 4'h5;
    localparam logic [3:0] ADDR_DIRECTION = 4'h6;

    // ------------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------------
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_COM_A_LSB = 4;
    localparam int CTL_COM_B_LSB = 6;

    // ------------------------------------------------------------------
    // Flag register bit positions
    // ------------------------------------------------------------------
    localparam int FLG_OVERFLOW = 0;
    localparam int FLG_CMP_A = 1;
    localparam int FLG_CMP_B = 2;
    localparam int FLG_CAPTURE = 3;
    localparam int FLG_W = 4;

    // ------------------------------------------------------------------
    // Direction register bit positions
    // ------------------------------------------------------------------
    localparam int DIR_A = 0;
    localparam int DIR_B = 1;

    // ------------------------------------------------------------------
    // Counter values and fixed TOP values
    // ------------------------------------------------------------------
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [15:0] ZERO16 = 16'h0000;

    // ------------------------------------------------------------------
    // Waveform modes handled here
    // ------------------------------------------------------------------
    localparam logic [3:0] MODE_PC_8 = 4'h1;
    localparam logic [3:0] MODE_PC_9 = 4'h2;
    localparam logic [3:0] MODE_PC_10 = 4'h3;
    localparam logic [3:0] MODE_FAST_8 = 4'h5;
    localparam logic [3:0] MODE_FAST_9 = 4'h6;
    localparam logic [3:0] MODE_FAST_10 = 4'h7;
    localparam logic [3:0] MODE_PC_CAPTURE = 4'ha;
    localparam logic [3:0] MODE_PC_CMP_A = 4'hb;
    localparam logic [3:0] MODE_FAST_CAPTURE = 4'he;
    localparam logic [3:0] MODE_FAST_CMP_A = 4'hf;

    // ------------------------------------------------------------------
    // Channel output mode codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        COM_OFF = 2'b00,
        COM_TOGGLE = 2'b01,
        COM_NONINV = 2'b10,
        COM_INV = 2'b11
    } output_mode_t;

endpackage : timer16_pwm_pkg

// ===== core/pwm_channel.sv
// One compare channel: double-buffered compare value and waveform level.
`timescale 1ns/100ps
module pwm_channel
    import timer16_pwm_pkg::*;
(
    input wire logic clk,                  // I/O clock.
    input wire logic rst_b,                // Asynchronous reset, active low.
    input wire logic tick,                 // Prescaled timer clock enable.
    input wire logic [15:0] counterValue,  // Current counter value.
    input wire logic countingUp,           // Effective slope in dual-slope modes.
    input wire logic atTop,                // Counter equals TOP.
    input wire logic isFast,               // Single-slope mode active.
    input wire logic isDual,               // Dual-slope mode active.
    input wire logic [1:0] outputMode,     // Channel output mode code.
    input wire logic toggleAllowed,        // Toggle code is honoured.
    input wire logic writeEn,              // Software writes the compare value.
    input wire logic [15:0] writeData,     // Compare value written.
    input wire logic [15:0] fixedMask,     // Bits kept on a write.
    input wire logic loadNow,              // Copy buffer into active compare.
    input wire logic loadDirect,           // Write goes straight to active.
    output logic [15:0] bufferValue,       // Buffered compare value.
    output logic [15:0] activeValue,       // Active compare value.
    output logic match,                    // Counter equals active compare.
    output logic level                     // Internal waveform level.
);

    typedef struct packed {
        logic [15:0] active;
        logic [15:0] buffer;
        logic level;
    } chan_state_t;

    chan_state_t state;
    chan_state_t next_state;
    output_mode_t com;

    assign com = output_mode_t'(outputMode);
    assign bufferValue = state.buffer;
    assign activeValue = state.active;
    assign level = state.level;
    assign match = (counterValue == state.active);

    // Next state: buffered writes, update at TOP and waveform level.
    always_comb begin
        next_state = state;
        if (writeEn) begin
            next_state.buffer = writeData & fixedMask;
            if (loadDirect) begin
                next_state.active = writeData & fixedMask;
            end
        end
        if (tick) begin
            if (loadNow) begin
                next_state.active = state.buffer;
            end
            case (com)
                COM_TOGGLE: begin
                    if (toggleAllowed && match) begin
                        next_state.level = ~state.level;
                    end
                end
                COM_NONINV: begin
                    if (isFast) begin
                        // Set at wrap wins, so compare at TOP stays high.
                        if (atTop) begin
                            next_state.level = 1'b1;
                        end else if (match) begin
                            next_state.level = 1'b0;
                        end
                    end else if (isDual && match) begin
                        next_state.level = ~countingUp;
                    end
                end
                COM_INV: begin
                    if (isFast) begin
                        if (atTop) begin
                            next_state.level = 1'b0;
                        end else if (match) begin
                            next_state.level = 1'b1;
                        end
                    end else if (isDual && match) begin
                        next_state.level = countingUp;
                    end
                end
                default: begin
                    next_state.level = state.level;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule : pwm_channel

// ===== core/timer16_pwm.sv
// Top of the 16-bit timer waveform generator: counter, flags and registers.
//
// How it works
// - Channel A compare writes land in a buffer while fast PWM uses it as TOP.
// - Buffer copies to active compare on the timer tick where counter equals TOP.
// - Fast PWM output changes on compare match and takes opposite level at wrap.
// - Waveform reaches the pin only when the pin direction bit selects output.
// - Fast PWM period is TOP plus one timer ticks.
// - Fast PWM compare at BOTTOM gives a one-tick spike each period.
// - Fast PWM compare at TOP gives a constant level set by polarity.
// - Fast mode 15 with output code 1 toggles channel A on each match.
// - Modes 1, 2, 3, 10, 11 count up to TOP then down to BOTTOM.
// - Phase correct non-inverting clears on up match, sets on down match.
// - Phase correct TOP is 0x00FF, 0x01FF, 0x03FF, capture, or channel A.
// - Register-defined TOP works from 0x0003 up to the full count.
// - Phase correct counter holds TOP for exactly one tick before reversing.
// - Channel compare flag sets whenever the counter matches its compare value.
// - Phase correct overflow flag sets when the counter reaches BOTTOM.
// - Register TOP sets channel A or capture flag at TOP, with the update.
// - Fixed TOP masks compare bits above the resolution on write.
// - Phase correct code two is non-inverted, code three inverted.
// - Phase correct period is two times TOP timer ticks.
// - Phase correct non-inverting compare at BOTTOM holds low, at TOP holds high.
// - Phase correct mode 11 with code 1 toggles channel A on matches.
// - Fast TOP is 0x00FF, 0x01FF, 0x03FF, capture, or channel A compare.
// - Fast PWM overflow flag sets each time the counter reaches TOP.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module timer16_pwm
    import timer16_pwm_pkg::*;
(
    input wire logic clk,                 // I/O clock, 100 MHz.
    input wire logic rst_b,               // Asynchronous reset, active low.
    input wire logic timerTick,           // Prescaled timer clock enable.
    input wire logic [3:0] regAddr,       // Register word address.
    input wire logic [15:0] regWriteData, // Register write data.
    input wire logic regWrite,            // Write strobe, one cycle.
    input wire logic regRead,             // Read strobe, one cycle.
    output logic [15:0] regReadData,      // Read data, cycle after the strobe.
    output logic channelAPinOut,          // Channel A pin level.
    output logic channelAPinOe,           // Channel A pin driven.
    output logic channelBPinOut,          // Channel B pin level.
    output logic channelBPinOe,           // Channel B pin driven.
    output logic overflowFlag,            // Overflow flag.
    output logic channelAFlag,            // Channel A compare flag.
    output logic channelBFlag,            // Channel B compare flag.
    output logic captureFlag              // Capture flag.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] comA;
        logic [1:0] comB;
        logic [15:0] counter;
        logic countDown;
        logic [15:0] capture;
        logic [FLG_W-1:0] flags;
        logic [1:0] direction;
        logic [15:0] readData;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    logic isFast;
    logic isDual;
    logic isFixed;
    logic [15:0] topValue;
    logic [15:0] fixedMask;
    logic atTop;
    logic atBottom;
    logic countingUp;
    logic loadNow;
    logic loadDirect;
    logic toggleA;
    logic writeA;
    logic writeB;
    logic matchA;
    logic matchB;
    logic levelA;
    logic levelB;
    logic [15:0] bufferA;
    logic [15:0] bufferB;
    logic [15:0] activeA;
    logic [FLG_W-1:0] flagSet;
    logic [15:0] controlWord;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------

    // Mode class and TOP source selection.
    always_comb begin
        isFast = 1'b0;
        isDual = 1'b0;
        isFixed = 1'b0;
        topValue = COUNT_MAX;
        case (state.mode)
            MODE_PC_8: begin
                isDual = 1'b1;
                isFixed = 1'b1;
                topValue = TOP_8BIT;
            end
            MODE_PC_9: begin
                isDual = 1'b1;
                isFixed = 1'b1;
                topValue = TOP_9BIT;
            end
            MODE_PC_10: begin
                isDual = 1'b1;
                isFixed = 1'b1;
                topValue = TOP_10BIT;
            end
            MODE_PC_CAPTURE: begin
                isDual = 1'b1;
                topValue = state.capture;
            end
            MODE_PC_CMP_A: begin
                isDual = 1'b1;
                topValue = activeA;
            end
            MODE_FAST_8: begin
                isFast = 1'b1;
                isFixed = 1'b1;
                topValue = TOP_8BIT;
            end
            MODE_FAST_9: begin
                isFast = 1'b1;
                isFixed = 1'b1;
                topValue = TOP_9BIT;
            end
            MODE_FAST_10: begin
                isFast = 1'b1;
                isFixed = 1'b1;
                topValue = TOP_10BIT;
            end
            MODE_FAST_CAPTURE: begin
                isFast = 1'b1;
                topValue = state.capture;
            end
            MODE_FAST_CMP_A: begin
                isFast = 1'b1;
                topValue = activeA;
            end
            default: begin
                topValue = COUNT_MAX;
            end
        endcase
    end

    // Counter position and slope as seen by the compare channels.
    assign fixedMask = isFixed ? topValue : COUNT_MAX;
    assign atTop = (state.counter == topValue);
    assign atBottom = (state.counter == BOTTOM);
    // BOTTOM counts as rising and TOP as falling, giving solid extreme levels.
    assign countingUp = atBottom ? 1'b1 : (atTop ? 1'b0 : ~state.countDown);
    assign loadNow = timerTick && atTop && (isFast || isDual);
    assign loadDirect = ~(isFast || isDual);
    assign toggleA = (state.mode == MODE_FAST_CMP_A) || (state.mode == MODE_PC_CMP_A);
    assign writeA = regWrite && (regAddr == ADDR_CMP_A);
    assign writeB = regWrite && (regAddr == ADDR_CMP_B);

    // ------------------------------------------------------------------
    // Compare channels
    // ------------------------------------------------------------------

    // Channel A may also supply TOP.
    pwm_channel chanA (
        .clk(clk),
        .rst_b(rst_b),
        .tick(timerTick),
        .counterValue(state.counter),
        .countingUp(countingUp),
        .atTop(atTop),
        .isFast(isFast),
        .isDual(isDual),
        .outputMode(state.comA),
        .toggleAllowed(toggleA),
        .writeEn(writeA),
        .writeData(regWriteData),
        .fixedMask(fixedMask),
        .loadNow(loadNow),
        .loadDirect(loadDirect),
        .bufferValue(bufferA),
        .activeValue(activeA),
        .match(matchA),
        .level(levelA)
    );

    // Channel B never toggles.
    pwm_channel chanB (
        .clk(clk),
        .rst_b(rst_b),
        .tick(timerTick),
        .counterValue(state.counter),
        .countingUp(countingUp),
        .atTop(atTop),
        .isFast(isFast),
        .isDual(isDual),
        .outputMode(state.comB),
        .toggleAllowed(1'b0),
        .writeEn(writeB),
        .writeData(regWriteData),
        .fixedMask(fixedMask),
        .loadNow(loadNow),
        .loadDirect(loadDirect),
        .bufferValue(bufferB),
        .activeValue(),
        .match(matchB),
        .level(levelB)
    );

    // ------------------------------------------------------------------
    // Flag events
    // ------------------------------------------------------------------

    // Events raised on a timer tick.
    always_comb begin
        flagSet = '0;
        if (timerTick) begin
            if (isFast) begin
                flagSet[FLG_OVERFLOW] = atTop;
            end else if (isDual) begin
                flagSet[FLG_OVERFLOW] = atBottom;
            end else begin
                flagSet[FLG_OVERFLOW] = (state.counter == COUNT_MAX);
            end
            flagSet[FLG_CMP_A] = matchA;
            flagSet[FLG_CMP_B] = matchB;
            flagSet[FLG_CAPTURE] = atTop && ((state.mode == MODE_FAST_CAPTURE)
                || (state.mode == MODE_PC_CAPTURE));
        end
    end

    assign controlWord = {8'h00, state.comB, state.comA, state.mode};

    // ------------------------------------------------------------------
    // Counter, registers and read port
    // ------------------------------------------------------------------

    // Next state of the counter and software-visible registers.
    always_comb begin
        next_state = state;
        if (timerTick) begin
            if (isFast) begin
                // Wrap after TOP gives a period of TOP plus one ticks.
                next_state.counter = atTop ? BOTTOM : state.counter + COUNT_ONE;
            end else if (isDual) begin
                if (atTop) begin
                    // TOP was shown for this one tick; now turn down.
                    next_state.countDown = 1'b1;
                    next_state.counter = state.counter - COUNT_ONE;
                end else if (atBottom) begin
                    next_state.countDown = 1'b0;
                    next_state.counter = state.counter + COUNT_ONE;
                end else if (state.countDown) begin
                    next_state.counter = state.counter - COUNT_ONE;
                end else begin
                    next_state.counter = state.counter + COUNT_ONE;
                end
            end else begin
                next_state.counter = state.counter + COUNT_ONE;
                next_state.countDown = 1'b0;
            end
        end
        // Set wins over a clear in the same cycle.
        next_state.flags = state.flags | flagSet;
        if (regWrite) begin
            case (regAddr)
                ADDR_CONTROL: begin
                    next_state.mode = regWriteData[CTL_MODE_LSB +: 4];
                    next_state.comA = regWriteData[CTL_COM_A_LSB +: 2];
                    next_state.comB = regWriteData[CTL_COM_B_LSB +: 2];
                end
                ADDR_COUNTER: begin
                    next_state.counter = regWriteData;
                end
                ADDR_CAPTURE: begin
                    next_state.capture = regWriteData;
                end
                ADDR_FLAGS: begin
                    next_state.flags = (state.flags & ~regWriteData[FLG_W-1:0]) | flagSet;
                end
                ADDR_DIRECTION: begin
                    next_state.direction = regWriteData[1:0];
                end
                default: begin
                    next_state.mode = state.mode;
                end
            endcase
        end
        // Read data stand only in the cycle after the strobe.
        next_state.readData = ZERO16;
        if (regRead) begin
            case (regAddr)
                ADDR_CONTROL: next_state.readData = controlWord;
                ADDR_COUNTER: next_state.readData = state.counter;
                ADDR_CMP_A: next_state.readData = bufferA;
                ADDR_CMP_B: next_state.readData = bufferB;
                ADDR_CAPTURE: next_state.readData = state.capture;
                ADDR_FLAGS: next_state.readData = {12'h000, state.flags};
                ADDR_DIRECTION: next_state.readData = {14'h0000, state.direction};
                default: next_state.readData = ZERO16;
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Pins are driven only when direction selects output and a code is set.
    assign channelAPinOut = levelA;
    assign channelAPinOe = state.direction[DIR_A] && (state.comA != COM_OFF);
    assign channelBPinOut = levelB;
    assign channelBPinOe = state.direction[DIR_B] && (state.comB != COM_OFF);
    assign regReadData = state.readData;
    assign overflowFlag = state.flags[FLG_OVERFLOW];
    assign channelAFlag = state.flags[FLG_CMP_A];
    assign channelBFlag = state.flags[FLG_CMP_B];
    assign captureFlag = state.flags[FLG_CAPTURE];

endmodule : timer16_pwm

// ===== sim/timer16_pwm_checker.sv
// Port-level assertions for the 16-bit timer waveform generator.
`timescale 1ns/100ps
module timer16_pwm_checker
    import timer16_pwm_pkg::*;
(
    input wire logic clk, // Clock.
    input wire logic rst_b, // Reset, active low.
    input wire logic timerTick, // Tick enable.
    input wire logic [3:0] regAddr, // Address.
    input wire logic [15:0] regWriteData, // Write data.
    input wire logic regWrite, // Write strobe.
    input wire logic regRead, // Read strobe.
    input wire logic [15:0] regReadData, // Read data.
    input wire logic channelAPinOut, // Pin A level.
    input wire logic channelAPinOe, // Pin A enable.
    input wire logic channelBPinOut, // Pin B level.
    input wire logic channelBPinOe, // Pin B enable.
    input wire logic overflowFlag, // Overflow flag.
    input wire logic channelAFlag, // Compare A flag.
    input wire logic channelBFlag, // Compare B flag.
    input wire logic captureFlag // Capture flag.
);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // A cycle with neither a tick nor a register write.
    sequence s_quiet;
        !timerTick && !regWrite;
    endsequence
    // A clear of all flags on a cycle without a tick.
    sequence s_clearAll;
        regWrite && regAddr == ADDR_FLAGS && regWriteData[3:0] == 4'hf && !timerTick;
    endsequence

    property p_flagsHold;
        s_quiet |=> $stable({overflowFlag, channelAFlag, channelBFlag, captureFlag});
    endproperty
    a_flagsHold: assert property (p_flagsHold) else $error("flags moved without tick");
    property p_pinHold;
        s_quiet |=> $stable(channelAPinOut) && $stable(channelBPinOut);
    endproperty
    a_pinHold: assert property (p_pinHold) else $error("pin moved without tick");
    property p_clear;
        s_clearAll |=> !overflowFlag && !channelAFlag && !channelBFlag && !captureFlag;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");
    property p_ovfRise;
        $rose(overflowFlag) |-> $past(timerTick);
    endproperty
    a_ovfRise: assert property (p_ovfRise) else $error("overflow set without tick");
    property p_flagRead;
        regRead && regAddr == ADDR_FLAGS |=> regReadData[FLG_CMP_A] == $past(channelAFlag);
    endproperty
    a_flagRead: assert property (p_flagRead) else $error("flag read wrong");
    property p_dirOffA;
        regWrite && regAddr == ADDR_DIRECTION && !regWriteData[DIR_A] |=> !channelAPinOe;
    endproperty
    a_dirOffA: assert property (p_dirOffA) else $error("pin A driven as input");
    property p_dirOffB;
        regWrite && regAddr == ADDR_DIRECTION && !regWriteData[DIR_B] |=> !channelBPinOe;
    endproperty
    a_dirOffB: assert property (p_dirOffB) else $error("pin B driven as input");
    property p_oeHold;
        !regWrite |=> $stable(channelAPinOe) && $stable(channelBPinOe);
    endproperty
    a_oeHold: assert property (p_oeHold) else $error("enable moved without write");
endmodule : timer16_pwm_checker

bind timer16_pwm timer16_pwm_checker chk_u (.*);

// ===== sim/timer16_pwm_tb.sv
// Self-checking bench for the 16-bit timer waveform generator.
`timescale 1ns/100ps
module timer16_pwm_tb import timer16_pwm_pkg::*;;
    logic clk = 1'b0, rst_b = 1'b0, timerTick = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWriteData = 16'h0000, regReadData;
    logic aOut, aOe, bOut, bOe;
    int n_errors = 0, checks_done = 0, tickDiv = 1 << 20, cyc = 0;

    // Clock and a tick enable every tickDiv cycles.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        timerTick <= ((cyc + 1) % tickDiv) == 0;
    end
    timer16_pwm dut_u (.clk(clk), .rst_b(rst_b), .timerTick(timerTick), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .channelAPinOut(aOut), .channelAPinOe(aOe),
        .channelBPinOut(bOut), .channelBPinOe(bOe), .overflowFlag(), .channelAFlag(),
        .channelBFlag(), .captureFlag());

    // Compares one value and reports a mismatch.
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    // Register write and read cycles.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string w);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(w, e, regReadData);
    endtask : rd
    // High cycles over four periods for one channel setting.
    function automatic int expHi(int fast, int com, int c, int t, int p);
        if (com == 1) return 2 * p;
        if (fast) return 4 * (com == 2 ? c + 1 : t - c);
        return 4 * (com == 2 ? 2 * c : 2 * t - 2 * c);
    endfunction : expHi
    // Programs a case, settles, then counts high cycles over four periods.
    task automatic run(input logic [3:0] m, input logic [1:0] ca, cb,
        input logic [15:0] t, va, vb, input int n, input logic prog);
        int fast, p, hiA = 0, hiB = 0;
        fast = m inside {4'h5, 4'he, 4'hf};
        p = fast ? t + 1 : 2 * t;
        tickDiv = n;
        if (prog) begin
            wr(ADDR_CONTROL, 16'h0000);
            wr(ADDR_CMP_A, va);
            wr(ADDR_CMP_B, vb);
            wr(ADDR_CAPTURE, t);
            wr(ADDR_CONTROL, {8'h00, cb, ca, m});
            wr(ADDR_COUNTER, 16'h0000);
        end
        repeat (2 * p * n + 100) @(posedge clk);
        wr(ADDR_FLAGS, 16'h000f);
        for (int i = 0; i < 4 * p * n; i++) begin
            @(posedge clk);
            #1;
            hiA += int'(aOut === 1'b1);
            hiB += int'(bOut === 1'b1);
        end
        chk("high A", 16'(expHi(fast, ca, va, t, p) * n), 16'(hiA));
        chk("high B", 16'(expHi(fast, cb, vb, t, p) * n), 16'(hiB));
        chk("enables", {14'h0, cb != 2'd0, ca != 2'd0}, {14'h0, bOe, aOe});
        rd(ADDR_FLAGS, m inside {4'ha, 4'he} ? 16'h000f : 16'h0007, "flags");
    endtask : run
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // Cuts a hang short.
    initial begin
        #900000;
        n_errors++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        logic [15:0] t, c;
        void'($urandom(91));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 10; a++)
            if (a != 1) rd(4'(a), 16'h0000, "reset value");
        wr(ADDR_DIRECTION, 16'h0003);
        run(4'h5, 2'd2, 2'd3, TOP_8BIT, 16'h0000, TOP_8BIT, 1, 1'b1);
        wr(ADDR_CMP_B, 16'h1234);
        rd(ADDR_CMP_B, 16'h0034, "masked compare");
        run(4'h1, 2'd2, 2'd2, TOP_8BIT, 16'h0000, TOP_8BIT, 1, 1'b1);
        run(4'hf, 2'd2, 2'd2, 16'h0003, 16'h0003, 16'h0000, 1, 1'b1);
        for (int k = 0; k < 2; k++) begin
            t = $urandom_range(40, 8);
            c = $urandom_range(t - 3, 2);
            run(4'hf, 2'd1, 2'd2, t, t, c, 1, 1'b1);
            wr(ADDR_CMP_A, 16'(c + 1));
            run(4'hf, 2'd1, 2'd2, 16'(c + 1), 16'(c + 1), c, 2, 1'b0);
            run(4'hb, 2'd1, 2'd2, t, t, c, 1, 1'b1);
            run(4'hb, 2'd3, 2'd3, t, t, c, 1, 1'b1);
            run(4'ha, 2'd2, 2'd2, t, 16'h0000, c, 1, 1'b1);
            run(4'he, 2'd2, 2'd3, t, 16'h0000, c, 2, 1'b1);
        end
        tickDiv = 1 << 20;
        wr(ADDR_FLAGS, 16'h000f);
        rd(ADDR_FLAGS, 16'h0000, "cleared flags");
        rd(4'h9, 16'h0000, "unmapped read");
        wr(ADDR_DIRECTION, 16'h0000);
        #1 chk("enables off", 16'h0000, {14'h0, bOe, aOe});
        tally_and_finish();
    end
endmodule : timer16_pwm_tb
